// ===== hw/bsc_bit_test.v
`timescale 1ns/1ps
`include "bsc_map.vh"

// decides whether a bit test skips the next instruction
module bsc_bit_test (
    // operand
    input wire [7:0] file_data,
    input wire [2:0] bit_sel,
    input wire [2:0] op,
    // result
    output wire skip
);
    wire bit_val;

    assign bit_val = file_data[bit_sel];
    assign skip = ((op == `BSC_OP_SKIP_CLR) && !bit_val) ||
                  ((op == `BSC_OP_SKIP_SET) && bit_val);
endmodule

// ===== hw/bsc_control.v
// Overview of operation
// - skip-if-clear reads the file register, skips next when bit is 0
// - skip-if-set reads the file register, skips next when bit is 1
// - taken skip turns fetched instruction into no-op; two cycles else one
// - both calls push address after the call onto return stack
// - immediate call: pc low from operand, pc high from high buffer
// - accumulator call: pc high from table pointer, pc low from accumulator
// - each call writes stack entry at pointer, then pointer plus one
`timescale 1ns/1ps
`include "bsc_map.vh"

module bsc_control (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // decoded instruction
    input wire instr_valid,
    input wire [2:0] op,
    input wire [7:0] operand,
    input wire [2:0] bit_sel,
    input wire [7:0] file_data,
    // address sources
    input wire [1:0] pc_high_buffer,
    input wire [7:0] table_high_pointer,
    input wire [7:0] accumulator,
    // program counter and stack
    output reg [9:0] pc,
    output reg [2:0] stack_ptr,
    output reg [9:0] stack_top,
    output reg push,
    output reg nop_slot,
    output reg busy,
    output reg flags_we
);
    localparam PC_W = `BSC_PC_W;
    localparam SP_W = `BSC_SP_W;
    localparam DEPTH = `BSC_STACK_DEPTH;
    localparam [1:0] ST_RUN = `BSC_ST_RUN;
    localparam [1:0] ST_FLUSH = `BSC_ST_FLUSH;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [PC_W-1:0] next_pc;
    reg [PC_W-1:0] stack_mem [0:DEPTH-1];
    wire skip;
    wire take;
    wire is_call;
    wire do_call;
    wire do_skip;
    wire do_plain;
    wire [PC_W-1:0] ret_addr;
    wire [PC_W-1:0] imm_target;
    wire [PC_W-1:0] acc_target;
    wire [PC_W-1:0] target;
    wire [DEPTH-1:0] ptr_sel;
    wire [DEPTH-1:0] entry_we;
    integer i;
    genvar gi;

    // sequential fetch step, shared by every path
    function [PC_W-1:0] f_step;
        input [PC_W-1:0] f_addr;
        begin
            f_step = f_addr + `BSC_PC_ONE;
        end
    endfunction

    function f_is_call;
        input [2:0] f_op;
        begin
            f_is_call = (f_op == `BSC_OP_CALL) ||
                (f_op == `BSC_OP_CALL_VIA_ACCUMULATOR);
        end
    endfunction

    // one-hot pick of the entry the pointer names
    function [DEPTH-1:0] f_sel;
        input [SP_W-1:0] f_ptr;
        integer k;
        begin
            f_sel = {DEPTH{1'b0}};
            for (k = 0; k < DEPTH; k = k + 1) begin
                if (f_ptr == k[SP_W-1:0]) begin
                    f_sel[k] = 1'b1;
                end
            end
        end
    endfunction

    bsc_bit_test bsc_bit_test_inst (
        .file_data(file_data),
        .bit_sel(bit_sel),
        .op(op),
        .skip(skip)
    );

    // a flushed slot refuses whatever is presented
    assign take = instr_valid && (state == ST_RUN);
    assign is_call = f_is_call(op);
    assign do_call = take && is_call;
    assign do_skip = take && !is_call && skip;
    assign do_plain = take && !is_call && !skip;

    assign ret_addr = f_step(pc);
    assign imm_target = {pc_high_buffer, operand};
    assign acc_target = {
        table_high_pointer[`BSC_TABLE_HIGH_POINTER_MSB:0],
        accumulator
    };
    assign target = (op == `BSC_OP_CALL_VIA_ACCUMULATOR) ? acc_target : imm_target;

    assign ptr_sel = f_sel(stack_ptr);

    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry_we
            assign entry_we[gi] = do_call && ptr_sel[gi];
        end
    endgenerate

    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                // both calls and taken skips lose the fetched word
                if (do_call || do_skip) begin
                    next_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always @* begin
        next_pc = pc;
        case (state)
            ST_RUN: begin
                if (do_call) begin
                    next_pc = target;
                end else if (do_skip || do_plain) begin
                    next_pc = f_step(pc);
                end
            end
            ST_FLUSH: begin
                // dead slot still moves on by one fetch
                next_pc = f_step(pc);
            end
            default: begin
                next_pc = pc;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ST_RUN;
            pc <= `BSC_PC_RST;
        end else begin
            state <= next_state;
            pc <= next_pc;
        end
    end

    // push side of the return stack
    always @(posedge clk_sys) begin
        if (!nrst) begin
            stack_ptr <= `BSC_SP_RST;
            stack_top <= `BSC_PC_RST;
            push <= 1'b0;
        end else begin
            push <= do_call;
            if (do_call) begin
                stack_top <= ret_addr;
                // pointer wraps; overflow is left to software
                stack_ptr <= stack_ptr + `BSC_SP_ONE;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                stack_mem[i] <= `BSC_PC_RST;
            end
        end else begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (entry_we[i]) begin
                    stack_mem[i] <= ret_addr;
                end
            end
        end
    end

    // slot markers
    always @(posedge clk_sys) begin
        if (!nrst) begin
            nop_slot <= 1'b0;
            busy <= 1'b0;
        end else begin
            nop_slot <= (next_state == ST_FLUSH);
            busy <= (next_state == ST_FLUSH);
        end
    end

    // none of these four write the status flags
    always @(posedge clk_sys) begin
        if (!nrst) begin
            flags_we <= 1'b0;
        end else begin
            flags_we <= 1'b0;
        end
    end
endmodule

// ===== include/bsc_map.vh
`ifndef BSC_MAP_VH
`define BSC_MAP_VH

// instruction classes presented by the decoder
`define BSC_OP_NONE 3'h0
`define BSC_OP_SKIP_CLR 3'h1
`define BSC_OP_SKIP_SET 3'h2
`define BSC_OP_CALL 3'h3
`define BSC_OP_CALL_VIA_ACCUMULATOR 3'h4
`define BSC_OP_OTHER 3'h5

// widths and reset values
`define BSC_PC_W 10
`define BSC_SP_W 3
`define BSC_STACK_DEPTH 8
`define BSC_PC_RST 10'h000
`define BSC_SP_RST 3'h0
`define BSC_PC_ONE 10'h001
`define BSC_SP_ONE 3'h1

// field positions
`define BSC_TABLE_HIGH_POINTER_MSB 1

// state codes
`define BSC_ST_RUN 2'h0
`define BSC_ST_FLUSH 2'h1

`endif

// ===== tb/bsc_control_test.sv
`timescale 1ns/1ps
module bsc_control_test;
    logic clk_sys = 0, nrst = 0, instr_valid = 0, push, nop_slot, busy, flags_we;
    logic [2:0] op = 0, bit_sel = 0, stack_ptr, s;
    logic [7:0] operand = 0, file_data = 0, table_high_pointer = 0;
    logic [7:0] accumulator = 0;
    logic [1:0] pc_high_buffer = 0;
    logic [9:0] pc, stack_top, p;
    int failures = 0, checked = 0;
    always #20 clk_sys = ~clk_sys;
    bsc_control bsc_control_inst(.*);
    bsc_stack bsc_stack_inst(.clk_sys, .push, .stack_ptr, .stack_top);
    task cmp(input logic [9:0] a, input logic [9:0] e);
        checked++;
        if (a !== e) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task run(input logic [2:0] o);
        @(posedge clk_sys) #1;
        p = pc;
        s = stack_ptr;
        op = o;
        instr_valid = 1;
        @(posedge clk_sys) #1 instr_valid = 0;
        cmp(flags_we, 0);
    endtask
    task t_call(input logic [2:0] o, input logic [9:0] e);
        run(o);
        cmp(pc, e);
        cmp(push, 1);
        cmp(stack_top, p + 10'h1);
        cmp(stack_ptr, s + 3'h1);
        @(posedge clk_sys) #1;
        cmp(bsc_stack_inst.mem[s], p + 10'h1);
        cmp(push, 0);
        cmp(pc, e + 10'h1);
    endtask
    task t_skip(input logic [2:0] o, input logic [7:0] d, input logic e);
        file_data = d;
        bit_sel = 3'h7;
        run(o);
        cmp(nop_slot, e);
        cmp(busy, e);
        cmp(pc, p + 10'h1);
        @(posedge clk_sys) #1 cmp(pc, p + 10'h1 + e);
        cmp(nop_slot, 0);
    endtask
    task t_plain;
        run(3'h5);
        cmp(nop_slot, 0);
        cmp(pc, p + 10'h1);
    endtask
    task t_refuse;
        file_data = 8'h00;
        bit_sel = 3'h0;
        @(posedge clk_sys) #1;
        p = pc;
        s = stack_ptr;
        op = 3'h1;
        instr_valid = 1;
        @(posedge clk_sys) #1 op = 3'h3;
        @(posedge clk_sys) #1 instr_valid = 0;
        cmp(stack_ptr, s);
        cmp(pc, p + 10'h2);
    endtask
    task finish_test;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 nrst = 1;
        pc_high_buffer = 2'h2;
        operand = 8'hff;
        t_call(3'h3, 10'h2ff);
        table_high_pointer = 8'hfe;
        accumulator = 8'h34;
        t_call(3'h4, 10'h234);
        t_skip(3'h1, 8'h7f, 1);
        t_skip(3'h1, 8'h80, 0);
        t_skip(3'h2, 8'h80, 1);
        t_skip(3'h2, 8'h7f, 0);
        t_plain;
        t_refuse;
        finish_test;
    end
endmodule

// ===== tb/bsc_props.sv
`timescale 1ns/1ps
module bsc_props(
    input wire clk_sys, nrst, instr_valid, push, nop_slot, busy, flags_we,
    input wire [2:0] op, bit_sel, stack_ptr,
    input wire [7:0] operand, file_data, table_high_pointer, accumulator,
    input wire [1:0] pc_high_buffer,
    input wire [9:0] pc, stack_top
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire take = instr_valid && !nop_slot;
    wire hit = file_data[bit_sel];
    wire call = take && (op == 3'h3 || op == 3'h4);
    sequence s_flush;
        nop_slot ##1 !nop_slot;
    endsequence
    chk_skip_clear:
        assert property (take && op == 3'h1 && !hit |=> s_flush)
        else $error("skip clear");
    chk_skip_set:
        assert property (take && op == 3'h2 && hit |=> s_flush)
        else $error("skip set");
    chk_no_skip:
        assert property (take && (op == 3'h1) == hit && op inside {1, 2}
            |=> !nop_slot && pc == $past(pc) + 10'h1) else $error("no skip");
    chk_call_push:
        assert property (call |=> push && stack_top == $past(pc) + 10'h1)
        else $error("push");
    chk_call_imm:
        assert property (take && op == 3'h3
            |=> pc == {$past(pc_high_buffer), $past(operand)}) else $error("imm");
    chk_call_acc:
        assert property (take && op == 3'h4 |=> pc ==
            {$past(table_high_pointer[1:0]), $past(accumulator)}) else $error("acc");
    chk_ptr_step:
        assert property (call |=> stack_ptr == $past(stack_ptr) + 3'h1)
        else $error("ptr");
    chk_flags_kept:
        assert property (take && op != 3'h5 |=> !flags_we) else $error("flags");
endmodule
bind bsc_control bsc_props bsc_props_inst(.*);

// ===== tb/bsc_stack.sv
`timescale 1ns/1ps
// return stack; pointer already stepped when push shows
module bsc_stack(
    input wire clk_sys,
    input wire push,
    input wire [2:0] stack_ptr,
    input wire [9:0] stack_top
);
    logic [9:0] mem [8];
    always @(posedge clk_sys)
        if (push) mem[stack_ptr - 3'h1] <= stack_top;
endmodule
